// ### dsw_consts.svh
// Offsets, field positions, reset values and timing counts of the status and warning outputs
`ifndef DSW_CONSTS_SVH
`define DSW_CONSTS_SVH

// ============================================================
// Clock and timing
`define DSW_CLK_HZ 100000000
`define DSW_FAN_STOP_S 1
`define DSW_LATCH_UNIT_S 1
`define DSW_LATCH_MAX_S 4'ha
`define DSW_LATCH_NO_LIMIT 4'h0

// ============================================================
// Detection thresholds
`define DSW_LOAD_WARN_PCT 8'h55
`define DSW_BATT_WARN_MV 12'hc80

// ============================================================
// Sizes
`define DSW_NUM_WARN 10
`define DSW_NUM_FUNC 10
`define DSW_NUM_SLOT 6

// ============================================================
// Warning index (selector code minus one)
`define DSW_W_OVERLOAD 0
`define DSW_W_REGEN 1
`define DSW_W_BATTERY 2
`define DSW_W_FAN 3
`define DSW_W_ENC_LINK 4
`define DSW_W_ENC_HEAT 5
`define DSW_W_OSCILL 6
`define DSW_W_LIFETIME 7
`define DSW_W_SCALE_ERR 8
`define DSW_W_SCALE_LINK 9

// ============================================================
// Mask bit of each warning in warning_mask_setting
`define DSW_MB_OVERLOAD 7
`define DSW_MB_REGEN 5
`define DSW_MB_BATTERY 0
`define DSW_MB_FAN 6
`define DSW_MB_ENC_LINK 4
`define DSW_MB_ENC_HEAT 3
`define DSW_MB_OSCILL 9
`define DSW_MB_LIFETIME 2
`define DSW_MB_SCALE_ERR 8
`define DSW_MB_SCALE_LINK 10

// ============================================================
// Status function codes for output slots
`define DSW_F_NONE 4'h0
`define DSW_F_TORQUE_LIMIT 4'h1
`define DSW_F_ZERO_SPEED 4'h2
`define DSW_F_SPEED_MATCH 4'h3
`define DSW_F_WARN_A 4'h4
`define DSW_F_WARN_B 4'h5
`define DSW_F_POS_CMD 4'h6
`define DSW_F_SPEED_LIMITED 4'h7
`define DSW_F_CLEARABLE_ALM 4'h8
`define DSW_F_SPEED_CMD 4'h9
`define DSW_F_SERVO_ON 4'ha

// ============================================================
// Register offsets (byte addresses)
`define DSW_REG_SELECT_A 8'h00
`define DSW_REG_SELECT_B 8'h04
`define DSW_REG_LATCH_TIME 8'h08
`define DSW_REG_MASK 8'h0c
`define DSW_REG_ENC_LIMIT 8'h10
`define DSW_REG_SCALE_LIMIT 8'h14
`define DSW_REG_LIFE_THRESH 8'h18
`define DSW_REG_WARN_LATCH 8'h1c
`define DSW_REG_WARN_RAW 8'h20
`define DSW_REG_SLOT_MAP 8'h24
`define DSW_REG_FUNC_STATE 8'h28

// ============================================================
// Reset values
`define DSW_RST_SELECT 4'h0
`define DSW_RST_LATCH_TIME 4'h1
`define DSW_RST_MASK 11'h000
`define DSW_RST_ERR_LIMIT 8'h08
`define DSW_RST_LIFE_THRESH 16'h03e8
`define DSW_RST_SLOT_MAP 24'h120000

`endif

// ### dsw_pkg.sv
// Types of the status and warning output block
package dsw_pkg;

    // ============================================================
    // Status conditions from the drive core
    typedef struct packed {
        logic torque_limiting;
        logic speed_is_zero;
        logic speed_coincident;
        logic pos_cmd_applied;
        logic speed_limited;
        logic alarm_clearable;
        logic speed_cmd_applied;
        logic servo_on;
    } dsw_cond_t;

    // ============================================================
    // Warning measurements from the drive core
    typedef struct packed {
        logic [7:0] load_pct;
        logic [7:0] regen_pct;
        logic [11:0] battery_mv;
        logic fan_stopped;
        logic [7:0] enc_err_run;
        logic enc_overheat;
        logic oscillation;
        logic [15:0] life_remain;
        logic scale_alarm;
        logic [7:0] scale_err_run;
    } dsw_warn_in_t;

    // ============================================================
    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dsw_bus_req_t;

    // ============================================================
    // Whole state of the block
    typedef struct packed {
        logic [3:0] sel_a;
        logic [3:0] sel_b;
        logic [3:0] latch_time;
        logic [10:0] mask;
        logic [7:0] enc_limit;
        logic [7:0] scale_limit;
        logic [15:0] life_thresh;
        logic [23:0] slot_map;
        logic [9:0] latched;
        logic [9:0][3:0] hold;
        logic [26:0] sec_div;
        logic [26:0] fan_cnt;
        logic [5:0] status_out;
        logic [31:0] rdata;
    } dsw_state_t;

endpackage : dsw_pkg

// ### dsw_status_outputs.sv
// Status and warning output logic of the servo drive with its register port
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "dsw_consts.svh"

// Functional notes
// R1 - Torque-limit function is on while torque is held at its limit.
// R2 - Zero-speed function is on while motor speed is zero.
// R3 - Speed-match function is on while actual speed equals commanded speed.
// R4 - Warning outputs A and B follow the warning chosen by their selector.
// R5 - Selector zero gives OR of all warnings; only codes 0 to 10 allowed.
// R6 - Overload warning when load factor is 85 % or more; code 1, mask bit 7.
// R7 - Regeneration warning when regen factor is 85 % or more; code 2, bit 5.
// R8 - Battery warning at 3.2 V or lower; code 3, bit 0, no time limit.
// R9 - Fan warning after fan stopped for 1 s; code 4, mask bit 6.
// R10 - Encoder link warning when error run exceeds limit; code 5, bit 4.
// R11 - Encoder overheat warning on encoder report; code 6, mask bit 3.
// R12 - Oscillation warning when vibration detected; code 7, mask bit 9.
// R13 - Lifetime warning when remaining life below threshold; code 8, bit 2.
// R14 - Scale error warning when feedback scale alarms; code 9, mask bit 8.
// R15 - Scale link warning when error run exceeds limit; code 10, bit 10.
// R16 - A mask bit of one suppresses detection of its warning.
// R17 - Latchable warnings hold 1 s to 10 s, or without limit.
// R18 - Position-command function is on while a position command is applied.
// R19 - Speed-limited function is on while torque control limits speed.
// R20 - Clearable-alarm function is on when the active alarm can be cleared.
// R21 - Speed-command function is on when speed command applied in speed control.
// R22 - Servo-on function is on while the servo is on.
// R23 - Each slot drives only its assigned function; unassigned slots stay off.
module dsw_status_outputs #(
    parameter int FAN_STOP_CYCLES = `DSW_FAN_STOP_S * `DSW_CLK_HZ,
    parameter int SEC_CYCLES = `DSW_LATCH_UNIT_S * `DSW_CLK_HZ
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire dsw_pkg::dsw_bus_req_t bus,
    output logic [31:0] rdata,
    // Drive core conditions
    input wire dsw_pkg::dsw_cond_t cond,
    input wire dsw_pkg::dsw_warn_in_t warn_in,
    // Assignable output slots, index 4 is output five, index 5 is output six
    output logic [5:0] status_output
);

    // ============================================================
    // Helper functions

    // Selector decode, shared by both warning outputs
    function automatic logic warn_pick(input logic [3:0] sel, input logic [9:0] act);
        logic r;
        r = 1'b0;
        if (sel == 4'h0) begin
            r = |act;
        end else if (sel <= 4'ha) begin
            r = act[sel - 4'h1];
        end
        return r;
    endfunction : warn_pick

    function automatic logic fixed_no_limit(input int i);
        return (i == `DSW_W_BATTERY) || (i == `DSW_W_LIFETIME);
    endfunction : fixed_no_limit

    // ============================================================
    // State

    dsw_pkg::dsw_state_t s_r;
    dsw_pkg::dsw_state_t s_nxt;

    logic [9:0] raw;
    logic [9:0] wmask;
    logic [9:0] det;
    logic [9:0] func;
    logic [9:0] clr;
    logic sec_tick;
    logic fan_full;
    logic [3:0] latch_eff;
    logic warn_a;
    logic warn_b;

    assign rdata = s_r.rdata;
    assign status_output = s_r.status_out;

    // ============================================================
    // Warning detection

    assign sec_tick = (s_r.sec_div == 27'(SEC_CYCLES - 1));
    assign fan_full = (s_r.fan_cnt == 27'(FAN_STOP_CYCLES));

    always_comb begin
        raw = '0;
        raw[`DSW_W_OVERLOAD] = warn_in.load_pct >= `DSW_LOAD_WARN_PCT; // R6
        raw[`DSW_W_REGEN] = warn_in.regen_pct >= `DSW_LOAD_WARN_PCT; // R7
        raw[`DSW_W_BATTERY] = warn_in.battery_mv <= `DSW_BATT_WARN_MV; // R8
        raw[`DSW_W_FAN] = fan_full; // R9
        raw[`DSW_W_ENC_LINK] = warn_in.enc_err_run > s_r.enc_limit; // R10
        raw[`DSW_W_ENC_HEAT] = warn_in.enc_overheat; // R11
        raw[`DSW_W_OSCILL] = warn_in.oscillation; // R12
        raw[`DSW_W_LIFETIME] = warn_in.life_remain < s_r.life_thresh; // R13
        raw[`DSW_W_SCALE_ERR] = warn_in.scale_alarm; // R14
        raw[`DSW_W_SCALE_LINK] = warn_in.scale_err_run > s_r.scale_limit; // R15
    end

    // Mask bits are scattered, so gather them into warning order
    always_comb begin
        wmask = '0;
        wmask[`DSW_W_OVERLOAD] = s_r.mask[`DSW_MB_OVERLOAD];
        wmask[`DSW_W_REGEN] = s_r.mask[`DSW_MB_REGEN];
        wmask[`DSW_W_BATTERY] = s_r.mask[`DSW_MB_BATTERY];
        wmask[`DSW_W_FAN] = s_r.mask[`DSW_MB_FAN];
        wmask[`DSW_W_ENC_LINK] = s_r.mask[`DSW_MB_ENC_LINK];
        wmask[`DSW_W_ENC_HEAT] = s_r.mask[`DSW_MB_ENC_HEAT];
        wmask[`DSW_W_OSCILL] = s_r.mask[`DSW_MB_OSCILL];
        wmask[`DSW_W_LIFETIME] = s_r.mask[`DSW_MB_LIFETIME];
        wmask[`DSW_W_SCALE_ERR] = s_r.mask[`DSW_MB_SCALE_ERR];
        wmask[`DSW_W_SCALE_LINK] = s_r.mask[`DSW_MB_SCALE_LINK];
    end

    assign det = raw & ~wmask; // R16
    assign latch_eff = (s_r.latch_time > `DSW_LATCH_MAX_S) ? `DSW_LATCH_MAX_S : s_r.latch_time;
    assign clr = (bus.wr && bus.addr == `DSW_REG_WARN_LATCH) ? bus.wdata[9:0] : 10'h000;

    assign warn_a = warn_pick(s_r.sel_a, s_r.latched); // R4 R5
    assign warn_b = warn_pick(s_r.sel_b, s_r.latched); // R4 R5

    // ============================================================
    // Status functions, bit n is function code n+1
    always_comb begin
        func = '0;
        func[0] = cond.torque_limiting; // R1
        func[1] = cond.speed_is_zero; // R2
        func[2] = cond.speed_coincident; // R3
        func[3] = warn_a; // R4
        func[4] = warn_b; // R4
        func[5] = cond.pos_cmd_applied; // R18
        func[6] = cond.speed_limited; // R19
        func[7] = cond.alarm_clearable; // R20
        func[8] = cond.speed_cmd_applied; // R21
        func[9] = cond.servo_on; // R22
    end

    // ============================================================
    // Next state
    always_comb begin
        logic [3:0] code;
        code = 4'h0;
        s_nxt = s_r;

        s_nxt.sec_div = sec_tick ? 27'h0 : s_r.sec_div + 27'h1;

        // Fan stop counter saturates so the warning stays while the fan is still
        if (!warn_in.fan_stopped) begin
            s_nxt.fan_cnt = 27'h0;
        end else if (!fan_full) begin // R9
            s_nxt.fan_cnt = s_r.fan_cnt + 27'h1;
        end

        // Latches: a fresh detection always beats a software clear
        for (int i = 0; i < `DSW_NUM_WARN; i++) begin
            if (det[i]) begin
                s_nxt.latched[i] = 1'b1;
                s_nxt.hold[i] = latch_eff; // R17
            end else if (s_r.latched[i]) begin
                if (clr[i]) begin
                    s_nxt.latched[i] = 1'b0;
                    s_nxt.hold[i] = 4'h0;
                end else if (fixed_no_limit(i) || s_r.latch_time == `DSW_LATCH_NO_LIMIT) begin
                    s_nxt.latched[i] = 1'b1; // R8 R13 R17
                end else if (sec_tick) begin
                    // Tick phase makes the hold up to one second shorter than set
                    if (s_r.hold[i] <= 4'h1) begin // R17
                        s_nxt.latched[i] = 1'b0;
                        s_nxt.hold[i] = 4'h0;
                    end else begin
                        s_nxt.hold[i] = s_r.hold[i] - 4'h1;
                    end
                end
            end
        end

        // Output slots
        for (int k = 0; k < `DSW_NUM_SLOT; k++) begin
            code = s_r.slot_map[k*4 +: 4];
            if (code != `DSW_F_NONE && code <= `DSW_F_SERVO_ON) begin // R23
                s_nxt.status_out[k] = func[code - 4'h1];
            end else begin
                s_nxt.status_out[k] = 1'b0; // R23
            end
        end

        // Register writes
        if (bus.wr) begin
            unique case (bus.addr)
                `DSW_REG_SELECT_A: s_nxt.sel_a = bus.wdata[3:0];
                `DSW_REG_SELECT_B: s_nxt.sel_b = bus.wdata[3:0];
                `DSW_REG_LATCH_TIME: s_nxt.latch_time = bus.wdata[3:0];
                `DSW_REG_MASK: s_nxt.mask = bus.wdata[10:0];
                `DSW_REG_ENC_LIMIT: s_nxt.enc_limit = bus.wdata[7:0];
                `DSW_REG_SCALE_LIMIT: s_nxt.scale_limit = bus.wdata[7:0];
                `DSW_REG_LIFE_THRESH: s_nxt.life_thresh = bus.wdata[15:0];
                `DSW_REG_SLOT_MAP: s_nxt.slot_map = bus.wdata[23:0];
                default: ;
            endcase
        end

        // Register reads: data stand only in the cycle after the strobe
        s_nxt.rdata = 32'h0;
        if (bus.rd) begin
            unique case (bus.addr)
                `DSW_REG_SELECT_A: s_nxt.rdata = {28'h0, s_r.sel_a};
                `DSW_REG_SELECT_B: s_nxt.rdata = {28'h0, s_r.sel_b};
                `DSW_REG_LATCH_TIME: s_nxt.rdata = {28'h0, s_r.latch_time};
                `DSW_REG_MASK: s_nxt.rdata = {21'h0, s_r.mask};
                `DSW_REG_ENC_LIMIT: s_nxt.rdata = {24'h0, s_r.enc_limit};
                `DSW_REG_SCALE_LIMIT: s_nxt.rdata = {24'h0, s_r.scale_limit};
                `DSW_REG_LIFE_THRESH: s_nxt.rdata = {16'h0, s_r.life_thresh};
                `DSW_REG_WARN_LATCH: s_nxt.rdata = {22'h0, s_r.latched};
                `DSW_REG_WARN_RAW: s_nxt.rdata = {22'h0, raw};
                `DSW_REG_SLOT_MAP: s_nxt.rdata = {8'h0, s_r.slot_map};
                `DSW_REG_FUNC_STATE: s_nxt.rdata = {22'h0, func};
                default: s_nxt.rdata = 32'h0;
            endcase
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.sel_a <= `DSW_RST_SELECT;
            s_r.sel_b <= `DSW_RST_SELECT;
            s_r.latch_time <= `DSW_RST_LATCH_TIME;
            s_r.mask <= `DSW_RST_MASK;
            s_r.enc_limit <= `DSW_RST_ERR_LIMIT;
            s_r.scale_limit <= `DSW_RST_ERR_LIMIT;
            s_r.life_thresh <= `DSW_RST_LIFE_THRESH;
            s_r.slot_map <= `DSW_RST_SLOT_MAP;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic clr_wr;
    assign clr_wr = bus.wr && bus.addr == `DSW_REG_WARN_LATCH;

    sequence seq_timed_expire;
        s_r.latched[`DSW_W_OSCILL] && !det[`DSW_W_OSCILL] && !clr_wr
            && s_r.latch_time != `DSW_LATCH_NO_LIMIT && s_r.hold[`DSW_W_OSCILL] == 4'h1
            && sec_tick;
    endsequence

    sequence seq_fan_about_full;
        warn_in.fan_stopped && s_r.fan_cnt == 27'(FAN_STOP_CYCLES - 1) && !s_r.mask[`DSW_MB_FAN];
    endsequence

    chk_slot_torque_limit: assert property ( // R1
        s_r.slot_map[23:20] == `DSW_F_TORQUE_LIMIT
            |=> status_output[5] == $past(cond.torque_limiting))
        else $error("torque limit slot does not follow its condition");

    chk_slot_zero_speed: assert property ( // R2
        s_r.slot_map[19:16] == `DSW_F_ZERO_SPEED
            |=> status_output[4] == $past(cond.speed_is_zero))
        else $error("zero speed slot does not follow its condition");

    chk_warn_or_all: assert property ( // R5
        s_r.sel_b == 4'h0 && s_r.slot_map[7:4] == `DSW_F_WARN_B
            |=> status_output[1] == $past(|s_r.latched))
        else $error("selector zero does not give the OR of all warnings");

    chk_warn_pick_battery: assert property ( // R4
        s_r.sel_a == 4'h3 && s_r.slot_map[3:0] == `DSW_F_WARN_A
            |=> status_output[0] == $past(s_r.latched[`DSW_W_BATTERY]))
        else $error("selector three does not pick the battery warning");

    chk_overload_detect: assert property ( // R6
        warn_in.load_pct >= 8'h55 && !s_r.mask[7] |=> s_r.latched[`DSW_W_OVERLOAD])
        else $error("overload at 85 percent not latched");

    chk_battery_no_limit: assert property ( // R8
        s_r.latched[`DSW_W_BATTERY] && !clr_wr |=> s_r.latched[`DSW_W_BATTERY])
        else $error("battery warning dropped without a clear");

    chk_fan_one_second: assert property ( // R9
        seq_fan_about_full ##1 warn_in.fan_stopped |=> s_r.latched[`DSW_W_FAN])
        else $error("fan warning missing after the stop time");

    chk_mask_blocks: assert property ( // R16
        s_r.mask[`DSW_MB_SCALE_LINK] && !s_r.latched[`DSW_W_SCALE_LINK]
            |=> !s_r.latched[`DSW_W_SCALE_LINK])
        else $error("masked warning was detected");

    chk_latch_expire: assert property ( // R17
        seq_timed_expire |=> !s_r.latched[`DSW_W_OSCILL])
        else $error("timed warning not released at hold end");

    chk_latch_reload: assert property ( // R17
        det[`DSW_W_OSCILL] |=> s_r.latched[`DSW_W_OSCILL]
            && s_r.hold[`DSW_W_OSCILL] == $past(latch_eff))
        else $error("hold time not reloaded on detection");

    chk_empty_slot_off: assert property ( // R23
        s_r.slot_map[11:8] == `DSW_F_NONE |=> !status_output[2])
        else $error("unassigned slot is driven");

    chk_read_mask: assert property (
        bus.rd && bus.addr == `DSW_REG_MASK |=> rdata == {21'h0, $past(s_r.mask)} ##1 rdata == 32'h0
            || $past(bus.rd))
        else $error("mask read data wrong or held too long");

    // Each warning latches in the cycle after its unmasked detection
    chk_regen_detect: assert property ( // R7
        warn_in.regen_pct >= 8'h55 && !s_r.mask[5] |=> s_r.latched[1])
        else $error("regeneration warning not latched");

    chk_enc_link_detect: assert property ( // R10
        warn_in.enc_err_run > s_r.enc_limit && !s_r.mask[4] |=> s_r.latched[4])
        else $error("encoder link warning not latched");

    chk_enc_heat_detect: assert property ( // R11
        warn_in.enc_overheat && !s_r.mask[3] |=> s_r.latched[5])
        else $error("encoder overheat warning not latched");

    chk_oscill_detect: assert property ( // R12
        warn_in.oscillation && !s_r.mask[9] |=> s_r.latched[6])
        else $error("oscillation warning not latched");

    chk_life_detect: assert property ( // R13
        warn_in.life_remain < s_r.life_thresh && !s_r.mask[2] |=> s_r.latched[7])
        else $error("lifetime warning not latched");

    chk_life_no_limit: assert property ( // R13
        s_r.latched[7] && !clr_wr |=> s_r.latched[7])
        else $error("lifetime warning dropped without a clear");

    chk_scale_err_detect: assert property ( // R14
        warn_in.scale_alarm && !s_r.mask[8] |=> s_r.latched[8])
        else $error("scale error warning not latched");

    chk_scale_link_detect: assert property ( // R15
        warn_in.scale_err_run > s_r.scale_limit && !s_r.mask[10] |=> s_r.latched[9])
        else $error("scale link warning not latched");

    // Slot zero shows its function one cycle after the condition
    chk_slot_speed_match: assert property ( // R3
        s_r.slot_map[3:0] == 4'h3 |=> status_output[0] == $past(cond.speed_coincident))
        else $error("speed match slot wrong");

    chk_slot_pos_cmd: assert property ( // R18
        s_r.slot_map[3:0] == 4'h6 |=> status_output[0] == $past(cond.pos_cmd_applied))
        else $error("position command slot wrong");

    chk_slot_speed_limited: assert property ( // R19
        s_r.slot_map[3:0] == 4'h7 |=> status_output[0] == $past(cond.speed_limited))
        else $error("speed limited slot wrong");

    chk_slot_clear_alarm: assert property ( // R20
        s_r.slot_map[3:0] == 4'h8 |=> status_output[0] == $past(cond.alarm_clearable))
        else $error("clearable alarm slot wrong");

    chk_slot_speed_cmd: assert property ( // R21
        s_r.slot_map[3:0] == 4'h9 |=> status_output[0] == $past(cond.speed_cmd_applied))
        else $error("speed command slot wrong");

    chk_slot_servo_on: assert property ( // R22
        s_r.slot_map[3:0] == 4'ha |=> status_output[0] == $past(cond.servo_on))
        else $error("servo on slot wrong");

endmodule : dsw_status_outputs

// ### dsw_host_model.sv
// Host controller model that latches the drive's status outputs
`timescale 1ns/1ps

// ============================================================
// Host input stage
module dsw_host_model (
    // Clock
    input wire logic clk,
    // Drive outputs and what the host has taken in
    input wire logic [5:0] status_output,
    output logic [5:0] seen
);
    // The host samples once per clock, so it sees a level one cycle late
    always_ff @(posedge clk) begin
        seen <= status_output;
    end
endmodule : dsw_host_model

// ### tb_top.sv
// Self-checking bench of the status and warning outputs
`timescale 1ns/1ps
`include "dsw_consts.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fail_count++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end

module tb_top;
    // ============================================================
    // Signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    dsw_pkg::dsw_bus_req_t bus = '0;
    dsw_pkg::dsw_cond_t cond = '0;
    dsw_pkg::dsw_warn_in_t warn_in;
    logic [31:0] rdata;
    logic [5:0] status_output;
    logic [5:0] seen;
    logic [31:0] rd_val;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    // Short counts keep the fan and latch timing within a brief run
    dsw_status_outputs #(.FAN_STOP_CYCLES(20), .SEC_CYCLES(10)) DUT (
        .clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
        .cond(cond), .warn_in(warn_in), .status_output(status_output)
    );
    dsw_host_model host (.clk(clk), .status_output(status_output), .seen(seen));

    always #5 clk = ~clk;

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    // ============================================================
    // Helpers
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        rd_val = rdata;
    endtask : rd

    // Quiet inputs: battery and life far from their thresholds
    function automatic dsw_pkg::dsw_warn_in_t idle();
        dsw_pkg::dsw_warn_in_t w;
        w = '0;
        w.battery_mv = 12'hfff;
        w.life_remain = 16'hffff;
        return w;
    endfunction : idle

    // Each warning driven onto the first value that sets it
    function automatic dsw_pkg::dsw_warn_in_t hit(input int i);
        dsw_pkg::dsw_warn_in_t w;
        w = idle();
        case (i)
            0: w.load_pct = `DSW_LOAD_WARN_PCT;
            1: w.regen_pct = `DSW_LOAD_WARN_PCT;
            2: w.battery_mv = `DSW_BATT_WARN_MV;
            3: w.fan_stopped = 1'b1;
            4: w.enc_err_run = `DSW_RST_ERR_LIMIT + 8'h01;
            5: w.enc_overheat = 1'b1;
            6: w.oscillation = 1'b1;
            7: w.life_remain = `DSW_RST_LIFE_THRESH - 16'h0001;
            8: w.scale_alarm = 1'b1;
            default: w.scale_err_run = `DSW_RST_ERR_LIMIT + 8'h01;
        endcase
        return w;
    endfunction : hit

    // ============================================================
    // Scenarios
    task automatic t_reset();
        rd(`DSW_REG_SELECT_A);
        `CHK("sel_a", 32'(`DSW_RST_SELECT), rd_val)
        rd(`DSW_REG_LATCH_TIME);
        `CHK("latch_time", 32'(`DSW_RST_LATCH_TIME), rd_val)
        tick(1);
        `CHK("rdata after", 32'h0, rdata)
        rd(`DSW_REG_MASK);
        `CHK("mask", 32'(`DSW_RST_MASK), rd_val)
        rd(`DSW_REG_SLOT_MAP);
        `CHK("slot_map", 32'(`DSW_RST_SLOT_MAP), rd_val)
        rd(8'h3c);
        `CHK("unmapped", 32'h0, rd_val)
        @(posedge clk);
        cond <= dsw_pkg::dsw_cond_t'(8'h80);
        tick(3);
        `CHK("slot5 torque", 6'h20, seen)
        cond <= dsw_pkg::dsw_cond_t'(8'h40);
        tick(3);
        `CHK("slot4 zero", 6'h10, seen)
        cond <= '0;
        $display("test reset done");
    endtask : t_reset

    task automatic t_status();
        logic [3:0] codes [8];
        codes = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};
        for (int k = 0; k < 8; k++) begin
            // Slot two carries an unlisted code and must stay off
            wr(`DSW_REG_SLOT_MAP, 32'h00000f00 | 32'(codes[k]));
            @(posedge clk);
            cond <= dsw_pkg::dsw_cond_t'(8'h80 >> k);
            tick(3);
            `CHK("own func", 6'h01, seen)
            cond <= dsw_pkg::dsw_cond_t'(~(8'h80 >> k));
            tick(3);
            `CHK("other func", 6'h00, seen)
        end
        cond <= '0;
        $display("test status done");
    endtask : t_status

    task automatic t_warn();
        wr(`DSW_REG_LATCH_TIME, 32'h0);
        wr(`DSW_REG_SLOT_MAP, 32'h00000054);
        wr(`DSW_REG_SELECT_B, 32'h0);
        for (int i = 0; i < 10; i++) begin
            wr(`DSW_REG_SELECT_A, 32'((i + 1) % 10 + 1));
            @(posedge clk);
            warn_in <= hit(i);
            tick(10);
            if (i == 3) `CHK("fan early", 6'h00, seen)
            tick(20);
            `CHK("wrong sel", 6'h02, seen)
            wr(`DSW_REG_SELECT_A, 32'(i + 1));
            tick(4);
            `CHK("own sel", 6'h03, seen)
            rd(`DSW_REG_WARN_LATCH);
            `CHK("latched", 32'(1 << i), rd_val)
            @(posedge clk);
            warn_in <= idle();
            tick(30);
            `CHK("no limit", 6'h03, seen)
            wr(`DSW_REG_WARN_LATCH, 32'h3ff);
            tick(4);
            `CHK("cleared", 6'h00, seen)
        end
        $display("test warn done");
    endtask : t_warn

    task automatic t_mask();
        wr(`DSW_REG_SELECT_A, 32'h1);
        wr(`DSW_REG_MASK, 32'h80);
        @(posedge clk);
        warn_in <= hit(0);
        tick(4);
        rd(`DSW_REG_WARN_LATCH);
        `CHK("masked latch", 32'h0, rd_val)
        `CHK("masked out", 6'h00, seen)
        wr(`DSW_REG_MASK, 32'h77f);
        tick(2);
        rd(`DSW_REG_WARN_LATCH);
        `CHK("unmasked latch", 32'h1, rd_val)
        @(posedge clk);
        warn_in.load_pct <= `DSW_LOAD_WARN_PCT - 8'h01;
        tick(3);
        rd(`DSW_REG_WARN_RAW);
        `CHK("below thresh", 32'h0, rd_val)
        wr(`DSW_REG_MASK, 32'h0);
        wr(`DSW_REG_WARN_LATCH, 32'h3ff);
        $display("test mask done");
    endtask : t_mask

    task automatic t_latch();
        dsw_pkg::dsw_warn_in_t w;
        w = hit(6);
        w.battery_mv = `DSW_BATT_WARN_MV;
        wr(`DSW_REG_LATCH_TIME, 32'h2);
        wr(`DSW_REG_SELECT_A, 32'h7);
        @(posedge clk);
        warn_in <= w;
        @(posedge clk);
        @(posedge clk);
        warn_in <= idle();
        tick(6);
        `CHK("held", 6'h03, seen)
        tick(24);
        `CHK("released", 6'h02, seen)
        rd(`DSW_REG_WARN_LATCH);
        `CHK("battery kept", 32'h004, rd_val)
        wr(`DSW_REG_WARN_LATCH, 32'h3ff);
        $display("test latch done");
    endtask : t_latch

    // ============================================================
    // Main sequence
    initial begin
        warn_in = idle();
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK("reset rdata", 32'h0, rdata)
        `CHK("reset out", 6'h00, status_output)
        t_reset();
        t_status();
        t_warn();
        t_mask();
        t_latch();
        give_verdict();
    end
endmodule : tb_top
